// file: core/spc_pkg.sv
// Shared constants and types for the second port configuration block
package spc_pkg;
	localparam logic [11:0] SPC_CFG_INDEX  = 12'h0C1;
	localparam logic [11:0] SPC_CFG_ADDR   = {SPC_CFG_INDEX[9:0], 2'h0};
	localparam logic [7:0]  SPC_CFG_RESET  = 8'h00;
	localparam int          SPC_BIT_EN     = 7;
	localparam int          SPC_BIT_INH    = 6;
	localparam int          SPC_BIT_BUSY   = 5;
	localparam int          SPC_BIT_EXT    = 4;
	localparam int          SPC_BIT_TOE    = 3;
	localparam int          SPC_BIT_FTE    = 2;
	localparam int          SPC_CS_LSB     = 0;
	localparam int          SPC_FREE_PERIODS = 10;
	localparam logic [1:0]  SPC_RESP_OKAY  = 2'h0;
	localparam logic [1:0]  SPC_RESP_SLVERR = 2'h2;

	typedef enum logic [1:0]
	{
		SPC_SRC_T0  = 2'h0,
		SPC_SRC_T5  = 2'h1,
		SPC_SRC_T2H = 2'h2,
		SPC_SRC_T2L = 2'h3
	} spc_src_t;

	typedef struct packed
	{
		logic     port_enable_bit;
		logic     slave_event_inhibit;
		logic     transfer_busy_flag;
		logic     data_hold_extension;
		logic     clock_low_timeout_enable;
		logic     bus_free_timeout_enable;
		spc_src_t bitrate_source_select;
	} spc_cfg_t;

	typedef struct packed
	{
		logic t0;
		logic t5;
		logic t2_hi;
		logic t2_lo;
	} spc_ovf_t;

	typedef struct packed
	{
		logic hi;
		logic lo;
	} spc_reload_t;
endpackage : spc_pkg

// file: core/spc_port_cfg.sv
// Second serial port configuration, bus monitor and register slave
//
// Function
// - Enable bit 7 activates port; clock and data lines monitored only while enabled.
// - Inhibit bit 6 blocks slave event interrupts; master interrupts pass.
// - Hardware sets read-only busy bit 5 while a bus transfer runs.
// - Busy clears on a sensed STOP or a bus-free timeout.
// - Bit 4 picks normal (0) or extended (1) data setup and hold.
// - Timeout enable bit 3 reloads timer while clock high, counts when low.
// - Timer in split mode: only its high byte held in reload.
// - Free timeout bit 2: bus free after over 10 source periods high.
// - Bits 1:0 pick timer 0, timer 5, timer 2 high or low overflow.
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module spc_port_cfg
#(
	parameter int FREE_PERIODS = spc_pkg::SPC_FREE_PERIODS
)
(
	input  wire logic               mclk,
	input  wire logic               srst,
	input  wire logic               link_clk,
	input  wire logic               scl_in,
	input  wire logic               sda_in,
	input  wire spc_pkg::spc_ovf_t  timer_ovf,
	input  wire logic               timer_split,
	input  wire logic               slave_event,
	input  wire logic               master_event,
	input  wire logic               s_axi_awvalid,
	output logic                    s_axi_awready,
	input  wire logic [11:0]        s_axi_awaddr,
	input  wire logic               s_axi_wvalid,
	output logic                    s_axi_wready,
	input  wire logic [31:0]        s_axi_wdata,
	input  wire logic [3:0]         s_axi_wstrb,
	output logic                    s_axi_bvalid,
	input  wire logic               s_axi_bready,
	output logic [1:0]              s_axi_bresp,
	input  wire logic               s_axi_arvalid,
	output logic                    s_axi_arready,
	input  wire logic [11:0]        s_axi_araddr,
	output logic                    s_axi_rvalid,
	input  wire logic               s_axi_rready,
	output logic [31:0]             s_axi_rdata,
	output logic [1:0]              s_axi_rresp,
	output logic                    port_enable_q,
	output logic                    data_hold_ext_q,
	output logic                    bitrate_tick_q,
	output spc_pkg::spc_reload_t    timer_reload_q,
	output logic                    port_irq_q
);
	import spc_pkg::*;

	localparam int CNT_W = $clog2(FREE_PERIODS + 2);
	localparam logic [CNT_W-1:0] FREE_LIMIT = CNT_W'(FREE_PERIODS + 1);

	// Link domain: pin sampling and START/STOP detection
	logic       lrst_s1_q, lrst_s1_d, lrst_q, lrst_d;
	logic       scl_s1_q, scl_s1_d, scl_l_q, scl_l_d;
	logic       sda_s1_q, sda_s1_d, sda_l_q, sda_l_d;
	logic       sda_p_q, sda_p_d;
	logic       en_s1_q, en_s1_d, en_l_q, en_l_d;
	logic       start_tg_q, start_tg_d;
	logic       stop_tg_q, stop_tg_d;

	always_comb
	begin
		lrst_s1_d = srst;
		lrst_d    = lrst_s1_q;
		scl_s1_d  = scl_in;
		scl_l_d   = scl_s1_q;
		sda_s1_d  = sda_in;
		sda_l_d   = sda_s1_q;
		sda_p_d   = sda_l_q;
		en_s1_d   = port_enable_q;
		en_l_d    = en_s1_q;
		start_tg_d = start_tg_q;
		stop_tg_d  = stop_tg_q;
		// Lines watched every link cycle while enabled
		if (en_l_q && scl_l_q && sda_p_q && !sda_l_q)
		begin
			start_tg_d = ~start_tg_q;
		end
		if (en_l_q && scl_l_q && !sda_p_q && sda_l_q)
		begin
			stop_tg_d = ~stop_tg_q;
		end
		if (lrst_q)
		begin
			sda_p_d    = 1'b1;
			start_tg_d = 1'b0;
			stop_tg_d  = 1'b0;
		end
	end

	always_ff @(posedge link_clk)
	begin
		lrst_s1_q  <= lrst_s1_d;
		lrst_q     <= lrst_d;
		scl_s1_q   <= scl_s1_d;
		scl_l_q    <= scl_l_d;
		sda_s1_q   <= sda_s1_d;
		sda_l_q    <= sda_l_d;
		sda_p_q    <= sda_p_d;
		en_s1_q    <= en_s1_d;
		en_l_q     <= en_l_d;
		start_tg_q <= start_tg_d;
		stop_tg_q  <= stop_tg_d;
	end

	// System domain: crossings from the link side
	logic [2:0] start_sy_q, start_sy_d;
	logic [2:0] stop_sy_q, stop_sy_d;
	logic [1:0] scl_sy_q, scl_sy_d;
	logic [1:0] sda_sy_q, sda_sy_d;
	logic       start_ev, stop_ev;
	logic       scl_m, sda_m;

	always_comb
	begin
		start_sy_d = {start_sy_q[1:0], start_tg_q};
		stop_sy_d  = {stop_sy_q[1:0], stop_tg_q};
		scl_sy_d   = {scl_sy_q[0], scl_l_q};
		sda_sy_d   = {sda_sy_q[0], sda_l_q};
		if (srst)
		begin
			start_sy_d = 3'h0;
			stop_sy_d  = 3'h0;
			scl_sy_d   = 2'h3;
			sda_sy_d   = 2'h3;
		end
	end

	always_ff @(posedge mclk)
	begin
		start_sy_q <= start_sy_d;
		stop_sy_q  <= stop_sy_d;
		scl_sy_q   <= scl_sy_d;
		sda_sy_q   <= sda_sy_d;
	end

	// Only the second and third stages are compared
	assign start_ev = start_sy_q[2] ^ start_sy_q[1];
	assign stop_ev  = stop_sy_q[2] ^ stop_sy_q[1];
	assign scl_m    = scl_sy_q[1];
	assign sda_m    = sda_sy_q[1];

	// Configuration, busy tracking and timer controls
	spc_cfg_t         cfg_q, cfg_d;
	logic [CNT_W-1:0] free_cnt_q, free_cnt_d;
	logic             src_ovf;
	logic             free_ev;
	logic             cfg_wr;
	logic [7:0]       cfg_wdata;
	logic             en_d, hold_d, tick_d, irq_d;
	spc_reload_t      reload_d;

	always_comb
	begin
		case (cfg_q.bitrate_source_select)
			SPC_SRC_T0:  src_ovf = timer_ovf.t0;
			SPC_SRC_T5:  src_ovf = timer_ovf.t5;
			SPC_SRC_T2H: src_ovf = timer_ovf.t2_hi;
			SPC_SRC_T2L: src_ovf = timer_ovf.t2_lo;
			default:     src_ovf = 1'b0;
		endcase
	end

	assign free_ev = cfg_q.port_enable_bit && (free_cnt_q == FREE_LIMIT);

	always_comb
	begin
		cfg_d      = cfg_q;
		free_cnt_d = free_cnt_q;
		// Counter restarts whenever either line is low
		if (!(cfg_q.port_enable_bit && cfg_q.bus_free_timeout_enable && scl_m && sda_m))
		begin
			free_cnt_d = '0;
		end
		else if (src_ovf && free_cnt_q != FREE_LIMIT)
		begin
			free_cnt_d = free_cnt_q + CNT_W'(1);
		end
		if (cfg_wr)
		begin
			cfg_d.port_enable_bit          = cfg_wdata[SPC_BIT_EN];
			cfg_d.slave_event_inhibit      = cfg_wdata[SPC_BIT_INH];
			cfg_d.data_hold_extension      = cfg_wdata[SPC_BIT_EXT];
			cfg_d.clock_low_timeout_enable = cfg_wdata[SPC_BIT_TOE];
			cfg_d.bus_free_timeout_enable  = cfg_wdata[SPC_BIT_FTE];
			cfg_d.bitrate_source_select    = spc_src_t'(cfg_wdata[SPC_CS_LSB +: 2]);
		end
		// Busy bit never follows the write data
		if (stop_ev || free_ev)
		begin
			cfg_d.transfer_busy_flag = 1'b0;
		end
		// A START in the same cycle wins over a STOP or timeout clear
		if (start_ev)
		begin
			cfg_d.transfer_busy_flag = 1'b1;
		end
		// Next enable, so no cycle shows busy with the port off
		if (!cfg_d.port_enable_bit)
		begin
			cfg_d.transfer_busy_flag = 1'b0;
		end
		en_d   = cfg_q.port_enable_bit;
		hold_d = cfg_q.data_hold_extension;
		tick_d = cfg_q.port_enable_bit && src_ovf;
		// Reload while the clock line is high, count while it is low
		reload_d.hi = cfg_q.port_enable_bit && cfg_q.clock_low_timeout_enable
			&& scl_m;
		reload_d.lo = reload_d.hi && !timer_split;
		irq_d = cfg_q.port_enable_bit
			&& ((slave_event && !cfg_q.slave_event_inhibit) || master_event);
		if (srst)
		begin
			cfg_d       = spc_cfg_t'(SPC_CFG_RESET);
			free_cnt_d  = '0;
			en_d        = 1'b0;
			hold_d      = 1'b0;
			tick_d      = 1'b0;
			reload_d    = '0;
			irq_d       = 1'b0;
		end
	end

	always_ff @(posedge mclk)
	begin
		cfg_q           <= cfg_d;
		free_cnt_q      <= free_cnt_d;
		port_enable_q   <= en_d;
		data_hold_ext_q <= hold_d;
		bitrate_tick_q  <= tick_d;
		timer_reload_q  <= reload_d;
		port_irq_q      <= irq_d;
	end

	// Register slave: one write and one read at a time
	logic        aw_held_q, aw_held_d;
	logic        w_held_q, w_held_d;
	logic [11:0] awaddr_q, awaddr_d;
	logic [7:0]  wdata_q, wdata_d;
	logic        wstrb_q, wstrb_d;
	logic        awready_d, wready_d, bvalid_d;
	logic [1:0]  bresp_d, rresp_d;
	logic        arready_d, rvalid_d;
	logic [31:0] rdata_d;
	logic        wr_hit;

	assign wr_hit    = (awaddr_q == SPC_CFG_ADDR);
	assign cfg_wr    = aw_held_q && w_held_q && !s_axi_bvalid && wr_hit && wstrb_q;
	assign cfg_wdata = wdata_q;

	always_comb
	begin
		aw_held_d = aw_held_q;
		w_held_d  = w_held_q;
		awaddr_d  = awaddr_q;
		wdata_d   = wdata_q;
		wstrb_d   = wstrb_q;
		bvalid_d  = s_axi_bvalid;
		bresp_d   = s_axi_bresp;
		rvalid_d  = s_axi_rvalid;
		rdata_d   = s_axi_rdata;
		rresp_d   = s_axi_rresp;
		if (s_axi_awvalid && s_axi_awready)
		begin
			aw_held_d = 1'b1;
			awaddr_d  = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			w_held_d = 1'b1;
			wdata_d  = s_axi_wdata[7:0];
			wstrb_d  = s_axi_wstrb[0];
		end
		if (s_axi_bvalid && s_axi_bready)
		begin
			bvalid_d = 1'b0;
		end
		// Unmapped writes are answered with an error, no effect
		if (aw_held_q && w_held_q && !s_axi_bvalid)
		begin
			aw_held_d = 1'b0;
			w_held_d  = 1'b0;
			bvalid_d  = 1'b1;
			bresp_d   = wr_hit ? SPC_RESP_OKAY : SPC_RESP_SLVERR;
		end
		if (s_axi_rvalid && s_axi_rready)
		begin
			rvalid_d = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready)
		begin
			rvalid_d = 1'b1;
			if (s_axi_araddr == SPC_CFG_ADDR)
			begin
				rdata_d = {24'h000000, cfg_q};
				rresp_d = SPC_RESP_OKAY;
			end
			else
			begin
				rdata_d = 32'h00000000;
				rresp_d = SPC_RESP_SLVERR;
			end
		end
		awready_d = !aw_held_d && !bvalid_d;
		wready_d  = !w_held_d && !bvalid_d;
		arready_d = !rvalid_d;
		if (srst)
		begin
			aw_held_d = 1'b0;
			w_held_d  = 1'b0;
			awaddr_d  = 12'h000;
			wdata_d   = 8'h00;
			wstrb_d   = 1'b0;
			bvalid_d  = 1'b0;
			bresp_d   = SPC_RESP_OKAY;
			rvalid_d  = 1'b0;
			rdata_d   = 32'h00000000;
			rresp_d   = SPC_RESP_OKAY;
			awready_d = 1'b0;
			wready_d  = 1'b0;
			arready_d = 1'b0;
		end
	end

	always_ff @(posedge mclk)
	begin
		aw_held_q     <= aw_held_d;
		w_held_q      <= w_held_d;
		awaddr_q      <= awaddr_d;
		wdata_q       <= wdata_d;
		wstrb_q       <= wstrb_d;
		s_axi_awready <= awready_d;
		s_axi_wready  <= wready_d;
		s_axi_bvalid  <= bvalid_d;
		s_axi_bresp   <= bresp_d;
		s_axi_arready <= arready_d;
		s_axi_rvalid  <= rvalid_d;
		s_axi_rdata   <= rdata_d;
		s_axi_rresp   <= rresp_d;
	end
endmodule : spc_port_cfg

// file: bench/spc_port_cfg_assertions.sv
// Port checker for the second port configuration block
`timescale 1ns/100ps
module spc_port_cfg_assertions
(
	input wire logic                 mclk,
	input wire logic                 srst,
	input wire logic                 master_event,
	input wire logic                 slave_event,
	input wire spc_pkg::spc_ovf_t    timer_ovf,
	input wire logic                 s_axi_awready,
	input wire logic                 s_axi_wready,
	input wire logic                 s_axi_bvalid,
	input wire logic                 s_axi_bready,
	input wire logic [1:0]           s_axi_bresp,
	input wire logic                 s_axi_rvalid,
	input wire logic                 s_axi_rready,
	input wire logic [31:0]          s_axi_rdata,
	input wire logic                 port_enable_q,
	input wire logic                 bitrate_tick_q,
	input wire spc_pkg::spc_reload_t timer_reload_q,
	input wire logic                 port_irq_q
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);
	a_tick_gate: assert property (bitrate_tick_q |-> port_enable_q && $past(timer_ovf) != 4'h0)
		else $error("tick without enable or overflow");
	a_irq_gate: assert property (port_irq_q |-> port_enable_q && ($past(slave_event) || $past(master_event)))
		else $error("interrupt without cause");
	a_master_irq: assert property ($past(master_event) && port_enable_q |-> port_irq_q)
		else $error("master interrupt lost");
	a_split_lo: assert property (timer_reload_q.lo |-> timer_reload_q.hi)
		else $error("low byte reload without high byte");
	a_busy_off: assert property (s_axi_rvalid && !s_axi_rdata[7] |-> !s_axi_rdata[5])
		else $error("busy read while disabled");
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	a_rdata_byte: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
		else $error("upper read bits not zero");
	a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write accepted during response");
endmodule : spc_port_cfg_assertions
bind spc_port_cfg spc_port_cfg_assertions u_chk (.mclk, .srst, .master_event, .slave_event,
	.timer_ovf, .s_axi_awready, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
	.s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .port_enable_q, .bitrate_tick_q,
	.timer_reload_q, .port_irq_q);

// file: bench/spc_bus_model.sv
// Behavioural bus neighbour making START and STOP on pulled-up lines
`timescale 1ns/100ps
module spc_bus_model
(
	input wire logic link_clk,
	input wire logic frame,
	input wire logic quiet,
	output logic     scl,
	output logic     sda
);
	initial {scl, sda} = 2'b11;
	always @(posedge frame)
	begin
		sda <= 1'b0;
		repeat (2) @(posedge link_clk);
		scl <= 1'b0;
	end
	// Quiet end raises data under a low clock, so no STOP shows
	always @(negedge frame)
	begin
		repeat (2) @(posedge link_clk);
		sda <= quiet;
		repeat (2) @(posedge link_clk);
		scl <= 1'b1;
		repeat (2) @(posedge link_clk);
		sda <= 1'b1;
	end
endmodule : spc_bus_model

// file: bench/spc_port_cfg_tb_top.sv
// Register and bus monitor tests for the second port configuration block
`timescale 1ns/100ps
module spc_port_cfg_tb_top;
	import spc_pkg::*;
	logic mclk = 0, srst = 1, link_clk = 0, scl, sda, split = 0, sev = 0, mev = 0;
	logic awv = 0, awr, wv = 0, wr_r, bv, br = 0, arv = 0, arr, rv, rr = 0;
	logic frame = 0, quiet = 0, en_q, ext_q, tick_q, irq_q;
	logic [11:0] awa = 0, ara = 0;
	logic [31:0] wd = 0, rd_d;
	logic [1:0]  bresp, rresp;
	spc_ovf_t    ovf = 0;
	spc_reload_t rl_q;
	int n_errors = 0, n_checks = 0, cs, i;
	localparam logic [11:0] A = SPC_CFG_ADDR;
	always #20 mclk = ~mclk;
	always #15 link_clk = ~link_clk;
	spc_bus_model u_bus (.link_clk(link_clk), .frame(frame), .quiet(quiet), .scl(scl), .sda(sda));
	// Short free count keeps the timeout scenario brief
	spc_port_cfg #(.FREE_PERIODS(2)) uut (.mclk(mclk), .srst(srst), .link_clk(link_clk),
		.scl_in(scl), .sda_in(sda), .timer_ovf(ovf), .timer_split(split), .slave_event(sev),
		.master_event(mev), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
		.s_axi_wvalid(wv), .s_axi_wready(wr_r), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
		.s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_bresp(bresp), .s_axi_arvalid(arv),
		.s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rr),
		.s_axi_rdata(rd_d), .s_axi_rresp(rresp), .port_enable_q(en_q),
		.data_hold_ext_q(ext_q), .bitrate_tick_q(tick_q), .timer_reload_q(rl_q),
		.port_irq_q(irq_q));
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r);
		@(posedge mclk);
		{awv, wv, awa, wd} <= {2'b11, a, 24'h0, d};
		fork
			begin do @(posedge mclk); while (awr !== 1'b1); awv <= 0; end
			begin do @(posedge mclk); while (wr_r !== 1'b1); wv <= 0; end
		join
		@(posedge mclk);
		br <= 1;
		do @(posedge mclk); while (bv !== 1'b1);
		br <= 0;
		chk({30'h0, bresp}, {30'h0, r});
	endtask : wr
	task rd(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] r);
		@(posedge mclk);
		{arv, ara} <= {1'b1, a};
		do @(posedge mclk); while (arr !== 1'b1);
		arv <= 0;
		@(posedge mclk);
		rr <= 1;
		do @(posedge mclk); while (rv !== 1'b1);
		rr <= 0;
		chk(rd_d, exp);
		chk({30'h0, rresp}, {30'h0, r});
	endtask : rd
	// One-cycle pulse on overflow and event inputs, then tick and interrupt
	task ev(input logic [5:0] v, input logic [1:0] exp);
		@(posedge mclk);
		{ovf, sev, mev} <= v;
		@(posedge mclk);
		{ovf, sev, mev} <= 6'h00;
		#1 chk({30'h0, tick_q, irq_q}, {30'h0, exp});
	endtask : ev
	task end_of_test;
		if (n_errors == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : end_of_test
	initial
	begin
		#400000;
		n_errors++;
		end_of_test();
	end
	initial
	begin
		repeat (12) @(posedge mclk);
		srst <= 0;
		rd(A, 32'h0, SPC_RESP_OKAY);
		rd(12'h300, 32'h0, SPC_RESP_SLVERR);
		wr(12'h300, 8'hFF, SPC_RESP_SLVERR);
		rd(A, 32'h0, SPC_RESP_OKAY);
		wr(A, 8'hFF, SPC_RESP_OKAY);
		rd(A, 32'hDF, SPC_RESP_OKAY);
		chk({30'h0, en_q, ext_q}, 32'h3);
		chk(rl_q, 32'h3);
		split <= 1;
		repeat (6) @(posedge mclk);
		chk(rl_q, 32'h2);
		split <= 0;
		wr(A, 8'h00, SPC_RESP_OKAY);
		#1 chk({30'h0, en_q, ext_q}, 32'h0);
		for (cs = 0; cs < 4; cs++)
		begin
			wr(A, 8'h80 | 8'(cs), SPC_RESP_OKAY);
			for (i = 0; i < 4; i++)
				ev({4'(1 << i), 2'b00}, {1'(i == 3 - cs), 1'b0});
		end
		wr(A, 8'hC0, SPC_RESP_OKAY);
		#1 chk({30'h0, en_q, ext_q}, 32'h2);
		ev(6'h02, 2'b00);
		ev(6'h01, 2'b01);
		wr(A, 8'h80, SPC_RESP_OKAY);
		ev(6'h02, 2'b01);
		wr(A, 8'h88, SPC_RESP_OKAY);
		frame <= 1;
		repeat (20) @(posedge mclk);
		chk(rl_q, 32'h0);
		rd(A, 32'hA8, SPC_RESP_OKAY);
		frame <= 0;
		repeat (20) @(posedge mclk);
		rd(A, 32'h88, SPC_RESP_OKAY);
		wr(A, 8'h84, SPC_RESP_OKAY);
		{quiet, frame} <= 2'b11;
		repeat (20) @(posedge mclk);
		frame <= 0;
		repeat (20) @(posedge mclk);
		ev(6'h20, 2'b10);
		ev(6'h20, 2'b10);
		rd(A, 32'hA4, SPC_RESP_OKAY);
		ev(6'h20, 2'b10);
		rd(A, 32'h84, SPC_RESP_OKAY);
		// Clock held low: software recovers by disabling and re-enabling
		frame <= 1;
		repeat (20) @(posedge mclk);
		rd(A, 32'hA4, SPC_RESP_OKAY);
		wr(A, 8'h00, SPC_RESP_OKAY);
		wr(A, 8'h84, SPC_RESP_OKAY);
		rd(A, 32'h84, SPC_RESP_OKAY);
		end_of_test();
	end
endmodule : spc_port_cfg_tb_top
